// >>> hdl/hkadc_pkg.sv
package hkadc_pkg;

   // special function register addresses
   localparam logic [7:0] ADDR_TEMP_RESULT   = 8'hD7;
   localparam logic [7:0] ADDR_CONV_START    = 8'hD8;
   localparam logic [7:0] ADDR_BATT_RESULT   = 8'hDF;
   localparam logic [7:0] ADDR_SUPPLY_RESULT = 8'hEF;
   localparam logic [7:0] ADDR_DELTA_CFG     = 8'hF3;
   localparam logic [7:0] ADDR_INTERVAL_CFG  = 8'hF9;
   localparam logic [7:0] ADDR_BATT_THRESH   = 8'hFA;

   // field positions
   localparam int SUPPLY_INTERVAL_LSB = 4;
   localparam int BATTERY_INTERVAL_LSB = 2;
   localparam int THERMAL_INTERVAL_LSB = 0;
   localparam int THERMAL_DELTA_LSB   = 3;
   localparam int SUPPLY_DELTA_LSB    = 0;
   localparam int BATTERY_START_BIT   = 0;
   localparam int THERMAL_START_BIT   = 1;
   localparam int SUPPLY_START_BIT    = 2;

   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [5:0] START_WRITE_MASK = 6'h07;

   // delta code that interrupts on every conversion
   localparam logic [2:0] DELTA_EVERY = 3'h7;
   localparam logic [2:0] DELTA_NONE  = 3'h0;

   // interval lengths in minutes for codes 01,10,11
   localparam int SUPPLY_MIN_01  = 8;
   localparam int SUPPLY_MIN_10  = 2;
   localparam int BATTERY_MIN_01 = 16;
   localparam int BATTERY_MIN_10 = 4;
   localparam int THERMAL_MIN_01 = 8;
   localparam int THERMAL_MIN_10 = 2;
   localparam int ANY_MIN_11     = 1;
   localparam int MINUTE_CNT_W   = 5;

   // timebase: clock rate and one minute in ticks of the low-rate timebase
   localparam int CLK_HZ         = 20_000_000;
   localparam int MINUTE_SECONDS = 60;
   localparam int TICK_HZ        = 1;
   localparam int TICKS_PER_MIN  = MINUTE_SECONDS * TICK_HZ;

   // channel indices
   localparam int CH_BATT   = 0;
   localparam int CH_TEMP   = 1;
   localparam int CH_SUPPLY = 2;
   localparam int N_CH      = 3;

endpackage

// >>> hdl/hkadc_scheduler.sv
`timescale 1ns/1ns
module hkadc_scheduler
#(
   parameter int TICKS_PER_MIN = hkadc_pkg::TICKS_PER_MIN
)
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       tick_en,
   input  wire logic       battery_power_mode,
   input  wire logic       sleep_power_mode,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic      [2:0] conv_req,
   input  wire logic [2:0] conv_ack,
   input  wire logic [2:0] conv_done,
   input  wire logic [7:0] conv_value,
   output logic            adc_irq
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0]       temp_result;
      logic [7:0]       batt_result;
      logic [7:0]       supply_result;
      logic [5:0]       delta_cfg;
      logic [7:0]       interval_cfg;
      logic [7:0]       batt_thresh;
      logic [2:0]       start;
      logic [2:0]       bg_pending;
      logic [2:0]       single_inflight;
      logic [5:0]       sec_cnt;
      logic [2:0][4:0]  min_cnt;
      logic [7:0]       rdata;
      logic             irq;
   } hkadc_state_t;

   hkadc_state_t st_reg;
   hkadc_state_t st_next;

   logic [2:0][1:0] sel;
   logic [2:0][4:0] period;
   logic [2:0]      due;
   logic [7:0]      last_val [3];
   logic [2:0]      fire;
   logic [2:0]      delta_sel [3];
   logic            minute_tick;
   logic            wr_interval;

   assign last_val[hkadc_pkg::CH_BATT]   = st_reg.batt_result;
   assign last_val[hkadc_pkg::CH_TEMP]   = st_reg.temp_result;
   assign last_val[hkadc_pkg::CH_SUPPLY] = st_reg.supply_result;
   // battery has no delta field; its background results report only through its threshold
   assign delta_sel[hkadc_pkg::CH_BATT]   = hkadc_pkg::DELTA_NONE;
   assign delta_sel[hkadc_pkg::CH_TEMP]   = st_reg.delta_cfg[5:3];
   assign delta_sel[hkadc_pkg::CH_SUPPLY] = st_reg.delta_cfg[2:0];

   assign sel[hkadc_pkg::CH_SUPPLY] = st_reg.interval_cfg[5:4];
   assign sel[hkadc_pkg::CH_BATT]   = st_reg.interval_cfg[3:2];
   assign sel[hkadc_pkg::CH_TEMP]   = st_reg.interval_cfg[1:0];

   // the power mode levels are not used: the scheduler and its interrupt
   // keep running in battery and sleep modes alike
   assign minute_tick = tick_en && (32'(st_reg.sec_cnt) == TICKS_PER_MIN - 1);
   assign wr_interval = sfr_wr && (sfr_addr == hkadc_pkg::ADDR_INTERVAL_CFG);

   ////////////////////////////////////////////////////////////////////////////
   // per-channel interval length and decision logic
   genvar g;
   generate
      for (g = 0; g < hkadc_pkg::N_CH; g++)
      begin : g_ch
         logic [8:0] diff;
         logic       beyond;
         logic       below;
         // each channel reads its own interval table
         if (g == hkadc_pkg::CH_BATT)
         begin : g_batt_len
            always_comb
            begin
               case (sel[g])
                  2'b01:   period[g] = 5'(hkadc_pkg::BATTERY_MIN_01);
                  2'b10:   period[g] = 5'(hkadc_pkg::BATTERY_MIN_10);
                  2'b11:   period[g] = 5'(hkadc_pkg::ANY_MIN_11);
                  default: period[g] = 5'h00;
               endcase
            end
         end
         else if (g == hkadc_pkg::CH_TEMP)
         begin : g_temp_len
            always_comb
            begin
               case (sel[g])
                  2'b01:   period[g] = 5'(hkadc_pkg::THERMAL_MIN_01);
                  2'b10:   period[g] = 5'(hkadc_pkg::THERMAL_MIN_10);
                  2'b11:   period[g] = 5'(hkadc_pkg::ANY_MIN_11);
                  default: period[g] = 5'h00;
               endcase
            end
         end
         else
         begin : g_supply_len
            always_comb
            begin
               case (sel[g])
                  2'b01:   period[g] = 5'(hkadc_pkg::SUPPLY_MIN_01);
                  2'b10:   period[g] = 5'(hkadc_pkg::SUPPLY_MIN_10);
                  2'b11:   period[g] = 5'(hkadc_pkg::ANY_MIN_11);
                  default: period[g] = 5'h00;
               endcase
            end
         end
         // a slot falls due on the minute tick that completes the interval
         assign due[g] = minute_tick && (sel[g] != 2'b00)
                         && (st_reg.min_cnt[g] == period[g] - 5'h01);
         // nine bits keep the distance unsigned with room for the compare
         assign diff = (conv_value >= last_val[g])
                       ? {1'b0, conv_value - last_val[g]}
                       : {1'b0, last_val[g] - conv_value};
         assign beyond = (delta_sel[g] == hkadc_pkg::DELTA_EVERY)
                         || ((delta_sel[g] != hkadc_pkg::DELTA_NONE)
                             && (diff > {6'h00, delta_sel[g]}));
         assign below = (g == hkadc_pkg::CH_BATT) && (conv_value < st_reg.batt_thresh);
         // single requests always report; background ones only on a change beyond the delta, on delta code 7, or on low battery
         assign fire[g] = conv_done[g] && (st_reg.single_inflight[g] || beyond || below);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_next = st_reg;
      st_next.irq = 1'b0;

      // a rewrite of the interval register restarts the sub-minute count as well,
      // so the first background slot comes one full interval after the write
      if (wr_interval)
      begin
         st_next.sec_cnt = 6'h00;
      end
      else if (tick_en)
      begin
         st_next.sec_cnt = minute_tick ? 6'h00 : st_reg.sec_cnt + 6'h01;
      end

      // converter handshake first, so a slot falling due on the ack edge survives
      for (int i = 0; i < hkadc_pkg::N_CH; i++)
      begin
         if (conv_ack[i])
         begin
            st_next.start[i] = 1'b0;
            st_next.single_inflight[i] = st_reg.start[i];
            st_next.bg_pending[i] = 1'b0;
         end
         if (conv_done[i])
         begin
            st_next.single_inflight[i] = 1'b0;
         end
      end

      // background slots, counted in whole minutes
      for (int i = 0; i < hkadc_pkg::N_CH; i++)
      begin
         if (wr_interval || sel[i] == 2'b00)
         begin
            st_next.min_cnt[i] = 5'h00;
         end
         else if (due[i])
         begin
            st_next.min_cnt[i] = 5'h00;
            st_next.bg_pending[i] = 1'b1;
         end
         else if (minute_tick)
         begin
            st_next.min_cnt[i] = st_reg.min_cnt[i] + 5'h01;
         end
      end

      // reserved bits of the start and delta registers are dropped on write
      if (sfr_wr)
      begin
         if (sfr_addr == hkadc_pkg::ADDR_TEMP_RESULT)
         begin
            st_next.temp_result = sfr_wdata;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_CONV_START)
         begin
            // the ack clear above is overridden only by a fresh set
            st_next.start = st_next.start | sfr_wdata[2:0];
         end
         else if (sfr_addr == hkadc_pkg::ADDR_BATT_RESULT)
         begin
            st_next.batt_result = sfr_wdata;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_SUPPLY_RESULT)
         begin
            st_next.supply_result = sfr_wdata;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_DELTA_CFG)
         begin
            st_next.delta_cfg = sfr_wdata[5:0];
         end
         else if (sfr_addr == hkadc_pkg::ADDR_INTERVAL_CFG)
         begin
            st_next.interval_cfg = sfr_wdata;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_BATT_THRESH)
         begin
            st_next.batt_thresh = sfr_wdata;
         end
      end

      // a conversion result wins over a same-cycle software write
      if (fire[hkadc_pkg::CH_BATT])
      begin
         st_next.batt_result = conv_value;
      end
      if (fire[hkadc_pkg::CH_TEMP])
      begin
         st_next.temp_result = conv_value;
      end
      if (fire[hkadc_pkg::CH_SUPPLY])
      begin
         st_next.supply_result = conv_value;
      end
      st_next.irq = |fire;

      // read data is captured once per strobe and held, so a late look still sees it
      if (sfr_rd)
      begin
         if (sfr_addr == hkadc_pkg::ADDR_TEMP_RESULT)
         begin
            st_next.rdata = st_reg.temp_result;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_CONV_START)
         begin
            st_next.rdata = {5'h00, st_reg.start};
         end
         else if (sfr_addr == hkadc_pkg::ADDR_BATT_RESULT)
         begin
            st_next.rdata = st_reg.batt_result;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_SUPPLY_RESULT)
         begin
            st_next.rdata = st_reg.supply_result;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_DELTA_CFG)
         begin
            st_next.rdata = {2'b00, st_reg.delta_cfg};
         end
         else if (sfr_addr == hkadc_pkg::ADDR_INTERVAL_CFG)
         begin
            st_next.rdata = st_reg.interval_cfg;
         end
         else if (sfr_addr == hkadc_pkg::ADDR_BATT_THRESH)
         begin
            st_next.rdata = st_reg.batt_thresh;
         end
         else
         begin
            // unmapped addresses read as zero
            st_next.rdata = hkadc_pkg::RESET_BYTE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // all zero after reset, which also leaves both deltas and all intervals off
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sfr_rdata = st_reg.rdata;
   assign adc_irq   = st_reg.irq;
   // one ack serves a start bit and a background slot together
   assign conv_req  = st_reg.start | st_reg.bg_pending;

endmodule // hkadc_scheduler

// >>> tb/hkadc_asserts.sv
`timescale 1ns/1ns
module hkadc_asserts
(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       tick_en,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [2:0] conv_req,
   input wire logic [2:0] conv_ack,
   input wire logic [2:0] conv_done,
   input wire logic       adc_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wire start_wr = sfr_wr && (sfr_addr == 8'hD8);
////////////////////////////////////////////////////////////////////////////////
   property p_unmapped;
      sfr_rd && !(sfr_addr inside {8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hF3, 8'hF9, 8'hFA})
         |=> sfr_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_delta_rsv;
      sfr_rd && sfr_addr == 8'hF3 |=> sfr_rdata[7:6] == 2'h0;
   endproperty
   a_delta_rsv: assert property (p_delta_rsv) else $error("delta top bits");
   property p_start_rsv;
      sfr_rd && sfr_addr == 8'hD8 |=> sfr_rdata[7:3] == 5'h00;
   endproperty
   a_start_rsv: assert property (p_start_rsv) else $error("start top bits");
   property p_rd_hold;
      !sfr_rd |=> $stable(sfr_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_start_req;
      start_wr && sfr_wdata[0] |=> conv_req[0];
   endproperty
   a_start_req: assert property (p_start_req) else $error("no request");
   // a tick at the ack edge may legally queue the next background request
   property p_ack_clr;
      conv_ack[1] && !(start_wr && sfr_wdata[1]) && !tick_en |=> !conv_req[1];
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("request kept");
   property p_irq_cause;
      adc_irq |-> $past(conv_done) != 3'h0;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
   property p_irq_pulse;
      adc_irq && (conv_done == 3'h0) |=> !adc_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   property p_req_cause;
      $rose(conv_req[2]) |-> $past(tick_en) || $past(start_wr);
   endproperty
   a_req_cause: assert property (p_req_cause) else $error("request uncaused");
   c_irq: cover property (adc_irq);
   c_ack: cover property (conv_ack[0]);
   c_sup: cover property ($rose(conv_req[2]));
endmodule // hkadc_asserts

bind hkadc_scheduler hkadc_asserts chk_u (.clk, .sys_rst, .tick_en, .sfr_wr, .sfr_rd,
   .sfr_addr, .sfr_wdata, .sfr_rdata, .conv_req, .conv_ack, .conv_done, .adc_irq);

// >>> tb/tb_housekeeping_adc_scheduler.sv
`timescale 1ns/1ns
module tb_housekeeping_adc_scheduler;
   logic       clk = 1'b0, sys_rst = 1'b1, tick_en = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic       battery_power_mode = 1'b0, sleep_power_mode = 1'b0, adc_irq;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, conv_value = 8'h00, sfr_rdata, v;
   logic [2:0] conv_ack = 3'h0, conv_done = 3'h0, conv_req, cyc = 3'h0;
   logic [7:0] adr [8] = '{8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hF3, 8'hF9, 8'hFA, 8'h00};
   logic [7:0] msk [8] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h00};
   logic [7:0] radr [3] = '{8'hDF, 8'hD7, 8'hEF};
   logic [7:0] lst [3];
   int         mins [3][3] = '{'{16, 4, 1}, '{8, 2, 1}, '{8, 2, 1}};
   int         sh [3] = '{2, 0, 4};
   int         fail_count = 0, n_checks = 0, n;
   logic [7:0] exp_q [$];
   always #25 clk = ~clk;
   // short minute keeps the 16 minute interval within a few hundred cycles
   hkadc_scheduler #(.TICKS_PER_MIN(2)) dut_u (.clk, .sys_rst, .tick_en, .battery_power_mode,
      .sleep_power_mode, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .conv_req,
      .conv_ack, .conv_done, .conv_value, .adc_irq);
   always @(posedge clk)
   begin
      cyc <= cyc + 3'h1;
      tick_en <= #2 (cyc == 3'h6);
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d fails=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic step;
      @(posedge clk);
      #2;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      step();
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
      step();
      {sfr_wr, sfr_rd, sfr_wdata} = {2'b00, ~d};
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic wait_req(input int ch);
      for (n = 0; n < 3000 && conv_req[ch] !== 1'b1; n++)
         step();
      if (n == 3000)
      begin
         fail_count++;
         final_report();
      end
   endtask
   task automatic conv(input int ch, input logic [7:0] d, input logic x);
      wait_req(ch);
      conv_ack[ch] = 1'b1;
      step();
      {conv_ack, conv_value} = {3'h0, d};
      conv_done[ch] = 1'b1;
      exp_q.push_back({7'h00, x});
      step();
      {conv_done, conv_value} = {3'h0, ~d};
   endtask
   // one result per strobe, never a read and a conversion in the same cycle
   always @(posedge clk)
   begin
      #1;
      if (sfr_rd === 1'b1 || conv_done !== 3'h0)
         cmp(sfr_rd ? sfr_rdata : {7'h00, adc_irq}, exp_q.pop_front());
   end
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32));
      repeat (3) @(posedge clk);
      #2;
      sys_rst = 1'b0;
      foreach (adr[i]) rd(adr[i], 8'h00);
      foreach (adr[i])
      begin
         v = (i == 5) ? 8'h00 : 8'($urandom);
         if (i != 1) bus(1'b1, adr[i], v);
         if (i != 1) rd(adr[i], v & msk[i]);
      end
      for (int c = 0; c < 3; c++)
      begin
         lst[c] = 8'($urandom_range(200, 20));
         bus(1'b1, 8'hD8, 8'h01 << c);
         rd(8'hD8, 8'h01 << c);
         conv(c, lst[c], 1'b1);
         rd(8'hD8, 8'h00);
         rd(radr[c], lst[c]);
      end
      bus(1'b1, 8'hF3, 8'h00);
      for (int c = 0; c < 3; c++)
         for (int b = 1; b < 4; b++)
         begin
            repeat (8) if (cyc != 3'h2) step();
            bus(1'b1, 8'hF9, 8'(b << sh[c]));
            wait_req(c);
            cmp(8'((n + 7) / 8), 8'(mins[c][b - 1] * 2));
            conv(c, 8'hFF, 1'b0);
         end
      v = 8'($urandom_range(200, 20));
      bus(1'b1, 8'hF9, 8'h0C);
      bus(1'b1, 8'hFA, v);
      conv(0, v, 1'b0);
      conv(0, v - 8'h01, 1'b1);
      rd(8'hDF, v - 8'h01);
      {battery_power_mode, sleep_power_mode} = 2'($urandom);
      bus(1'b1, 8'hF9, 8'h33);
      for (int c = 1; c < 3; c++)
         for (int d = 0; d < 8; d++)
         begin
            bus(1'b1, 8'hF3, 8'(d << (c == 1 ? 3 : 0)));
            conv(c, lst[c] + 8'(d), d == 7);
            if (d == 7) lst[c] += 8'(d);
            conv(c, lst[c] + 8'(d + 1), d != 0);
            if (d != 0) lst[c] += 8'(d + 1);
            rd(radr[c], lst[c]);
         end
      step();
      final_report();
   end
endmodule // tb_housekeeping_adc_scheduler
